//--- common/osc_ctrl_params.svh
// Register offsets, field positions, reset values and timing counts for
// the oscillator select control block. Assumes inclusion by bare name.
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH

`define OSC_PERIPH_NUM        8'h04
`define OSC_REG_GENERAL       8'h00
`define OSC_REG_INTERNAL      8'h01
`define OSC_REG_CRYSTAL       8'h02

`define OSC_GEN_SEL_BIT       0
`define OSC_GEN_RST_BIT       1
`define OSC_INT_EN_BIT        0
`define OSC_INT_SLOW_BIT      1
`define OSC_XTAL_EN_BIT       0
`define OSC_XTAL_BIAS_BIT     1

`define OSC_GEN_RST_RESET     1'b0
`define OSC_INT_EN_RESET      1'b1
`define OSC_INT_SLOW_RESET    1'b0
`define OSC_XTAL_EN_RESET     1'b1
`define OSC_XTAL_BIAS_RESET   1'b1

// Tile reset hold after the new source reports running, in ns
`define OSC_RST_HOLD_NS       64
`define OSC_CLK_PERIOD_NS     8
`define OSC_RST_HOLD_CYC      ((`OSC_RST_HOLD_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)

`endif

//--- common/osc_ctrl_pkg.sv
// Types shared by the oscillator select control block.
// Assumes the params header is compiled alongside.
package osc_ctrl_pkg;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] periph;
    logic [7:0] addr;
    logic [7:0] wdata;
  } periph_req_s;

  typedef struct packed {
    logic       xtal_en;
    logic       xtal_bias_en;
    logic       int_en;
    logic       int_slow;
  } osc_ctrl_s;

  typedef enum logic [3:0] {
    SW_IDLE = 4'b0001,
    SW_STOP = 4'b0010,
    SW_WAIT = 4'b0100,
    SW_HOLD = 4'b1000
  } switch_state_e;

endpackage : osc_ctrl_pkg

//--- hdl/oscillator_select_control.sv
// Oscillator select control: three byte registers on the peripheral
// byte port, clock source select with glitch-free switch, tile reset.
// Assumes the request struct is from same-clock logic, one per cycle.
`include "osc_ctrl_params.svh"

module oscillator_select_control
  import osc_ctrl_pkg::*;
  (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        strap_sel_in,
    input  periph_req_s      req_in,
    input  wire logic        xtal_ready_in,
    input  wire logic        int_ready_in,
    output logic [7:0]       rdata_out,
    output logic             rvalid_out,
    output logic             sel_internal_out,
    output logic             gate_xtal_out,
    output logic             gate_int_out,
    output osc_ctrl_s        osc_ctrl_out,
    output logic             tile_reset_out
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;

  two_flop_sync #(.WIDTH(3)) u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  ({strap_sel_in, xtal_ready_in, int_ready_in}),
    .sync_out  (pins_sync)
  );

  logic strap_s;
  logic xtal_rdy_s;
  logic int_rdy_s;
  assign strap_s    = pins_sync[2];
  assign xtal_rdy_s = pins_sync[1];
  assign int_rdy_s  = pins_sync[0];

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  function automatic logic hit(input periph_req_s r, input logic [7:0] off);
    hit = r.valid && (r.periph == `OSC_PERIPH_NUM) && (r.addr == off);
  endfunction : hit

  // Strap caught once the synchroniser holds its real level, not under reset
  logic [1:0] strap_arm_q,  strap_arm_d;
  logic       strap_done_q, strap_done_d;
  logic       sel_q,        sel_d;
  logic       rst_on_chg_q, rst_on_chg_d;
  osc_ctrl_s  ctrl_q,       ctrl_d;
  logic [7:0] rdata_q,      rdata_d;
  logic       rvalid_q,     rvalid_d;

  always_comb
  begin
    // Two edges for the synchroniser to fill before the strap is trusted
    strap_arm_d  = {strap_arm_q[0], 1'b1};
    strap_done_d = strap_arm_q[1];
    sel_d        = sel_q;
    rst_on_chg_d = rst_on_chg_q;
    ctrl_d       = ctrl_q;
    rdata_d      = rdata_q;
    rvalid_d     = 1'b0;
    if (!strap_done_q)
      sel_d = strap_s;
    if (req_in.write && strap_done_q)
    begin
      if (hit(req_in, `OSC_REG_GENERAL))
      begin
        sel_d        = req_in.wdata[`OSC_GEN_SEL_BIT];
        rst_on_chg_d = req_in.wdata[`OSC_GEN_RST_BIT];
      end
      if (hit(req_in, `OSC_REG_INTERNAL))
      begin
        ctrl_d.int_en   = req_in.wdata[`OSC_INT_EN_BIT];
        ctrl_d.int_slow = req_in.wdata[`OSC_INT_SLOW_BIT];
      end
      if (hit(req_in, `OSC_REG_CRYSTAL))
      begin
        ctrl_d.xtal_en      = req_in.wdata[`OSC_XTAL_EN_BIT];
        ctrl_d.xtal_bias_en = req_in.wdata[`OSC_XTAL_BIAS_BIT];
      end
    end
    if (req_in.valid && !req_in.write && req_in.periph == `OSC_PERIPH_NUM)
    begin
      rvalid_d = 1'b1;
      rdata_d  = 8'h00;
      if (hit(req_in, `OSC_REG_GENERAL))
      begin
        rdata_d[`OSC_GEN_SEL_BIT] = sel_q;
        rdata_d[`OSC_GEN_RST_BIT] = rst_on_chg_q;
      end
      if (hit(req_in, `OSC_REG_INTERNAL))
      begin
        rdata_d[`OSC_INT_EN_BIT]   = ctrl_q.int_en;
        rdata_d[`OSC_INT_SLOW_BIT] = ctrl_q.int_slow;
      end
      if (hit(req_in, `OSC_REG_CRYSTAL))
      begin
        rdata_d[`OSC_XTAL_EN_BIT]   = ctrl_q.xtal_en;
        rdata_d[`OSC_XTAL_BIAS_BIT] = ctrl_q.xtal_bias_en;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      strap_arm_q  <= 2'h0;
      strap_done_q <= 1'b0;
      sel_q        <= 1'b0;
      rst_on_chg_q <= `OSC_GEN_RST_RESET;
      ctrl_q       <= '{xtal_en:      `OSC_XTAL_EN_RESET,
                        xtal_bias_en: `OSC_XTAL_BIAS_RESET,
                        int_en:       `OSC_INT_EN_RESET,
                        int_slow:     `OSC_INT_SLOW_RESET};
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
    end
    else
    begin
      strap_arm_q  <= strap_arm_d;
      strap_done_q <= strap_done_d;
      sel_q        <= sel_d;
      rst_on_chg_q <= rst_on_chg_d;
      ctrl_q       <= ctrl_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free source switch and tile reset
  // ----------------------------------------------------------------
  localparam logic [3:0] HOLD_CYC = 4'(`OSC_RST_HOLD_CYC);

  switch_state_e st_q, st_d;
  logic       act_sel_q,   act_sel_d;
  logic       gx_q,        gx_d;
  logic       gi_q,        gi_d;
  logic       trst_q,      trst_d;
  logic       with_rst_q,  with_rst_d;
  logic [3:0] cnt_q,       cnt_d;
  logic       new_ready;

  // Readiness of the source being switched to, not of a later request
  assign new_ready = act_sel_q ? int_rdy_s : xtal_rdy_s;

  always_comb
  begin
    st_d       = st_q;
    act_sel_d  = act_sel_q;
    gx_d       = gx_q;
    gi_d       = gi_q;
    trst_d     = trst_q;
    with_rst_d = with_rst_q;
    cnt_d      = cnt_q;
    case (st_q)
      SW_IDLE:
      begin
        gx_d   = !act_sel_q;
        gi_d   = act_sel_q;
        trst_d = 1'b0;
        if (strap_done_q && sel_q != act_sel_q)
        begin
          gx_d       = 1'b0;
          gi_d       = 1'b0;
          with_rst_d = rst_on_chg_q;
          trst_d     = rst_on_chg_q;
          st_d       = SW_STOP;
        end
      end
      SW_STOP:
      begin
        act_sel_d = sel_q;
        st_d      = SW_WAIT;
      end
      SW_WAIT:
      begin
        if (new_ready)
        begin
          gx_d  = !act_sel_q;
          gi_d  = act_sel_q;
          cnt_d = HOLD_CYC;
          st_d  = with_rst_q ? SW_HOLD : SW_IDLE;
        end
      end
      SW_HOLD:
      begin
        if (cnt_q == 4'h0)
        begin
          trst_d = 1'b0;
          st_d   = SW_IDLE;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      default:
        st_d = SW_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q       <= SW_IDLE;
      act_sel_q  <= 1'b0;
      gx_q       <= 1'b0;
      gi_q       <= 1'b0;
      trst_q     <= 1'b0;
      with_rst_q <= 1'b0;
      cnt_q      <= 4'h0;
    end
    else
    begin
      st_q       <= st_d;
      act_sel_q  <= act_sel_d;
      gx_q       <= gx_d;
      gi_q       <= gi_d;
      trst_q     <= trst_d;
      with_rst_q <= with_rst_d;
      cnt_q      <= cnt_d;
    end
  end

  assign rdata_out        = rdata_q;
  assign rvalid_out       = rvalid_q;
  assign sel_internal_out = act_sel_q;
  assign gate_xtal_out    = gx_q;
  assign gate_int_out     = gi_q;
  assign osc_ctrl_out     = ctrl_q;
  assign tile_reset_out   = trst_q;

endmodule : oscillator_select_control

//--- hdl/two_flop_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no word coherency is implied.
module two_flop_sync
  #(parameter int WIDTH = 1)
  (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
  );

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : two_flop_sync

//--- tb/osc_ctrl_monitor.sv
// Checker for the oscillator select control port behaviour.
// Assumes binding onto the design top; one clock domain.
module osc_ctrl_monitor
  import osc_ctrl_pkg::*;
  (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       strap_sel_in,
    input  periph_req_s     req_in,
    input  wire logic       xtal_ready_in,
    input  wire logic       int_ready_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       rvalid_out,
    input  wire logic       sel_internal_out,
    input  wire logic       gate_xtal_out,
    input  wire logic       gate_int_out,
    input  osc_ctrl_s       osc_ctrl_out,
    input  wire logic       tile_reset_out
  );
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  logic rd_take;
  logic wr_take;
  assign rd_take = req_in.valid && !req_in.write && req_in.periph == 8'h04;
  assign wr_take = req_in.valid && req_in.write && req_in.periph == 8'h04;
  sequence src_change;
    $changed(sel_internal_out);
  endsequence
  sequence gates_shut;
    !gate_xtal_out && !gate_int_out;
  endsequence
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  chk_rd_answer: assert property (rvalid_out == $past(rd_take))
    else $error("read answer does not follow a read of this peripheral");
  chk_rd_reserved: assert property (rvalid_out |-> rdata_out[7:2] == 6'h00)
    else $error("reserved read bits not zero");
  chk_rd_unmapped: assert property (rd_take && req_in.addr > 8'h02 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_int_write: assert property (wr_take && req_in.addr == 8'h01 |=>
    osc_ctrl_out.int_en == $past(req_in.wdata[0]) && osc_ctrl_out.int_slow == $past(req_in.wdata[1]))
    else $error("internal oscillator control not updated");
  chk_xtal_write: assert property (wr_take && req_in.addr == 8'h02 |=>
    osc_ctrl_out.xtal_en == $past(req_in.wdata[0])
    && osc_ctrl_out.xtal_bias_en == $past(req_in.wdata[1]))
    else $error("crystal control not updated");
  // ----------------------------------------
  // Source switch
  // ----------------------------------------
  chk_gate_excl: assert property (!(gate_xtal_out && gate_int_out))
    else $error("both clock gates open");
  chk_gate_source: assert property ((gate_int_out |-> sel_internal_out)
    and (gate_xtal_out |-> !sel_internal_out))
    else $error("open gate does not match source");
  chk_src_break: assert property (src_change |-> gates_shut)
    else $error("source changed with a gate open");
  chk_trst_src: assert property ($rose(tile_reset_out) |=> src_change)
    else $error("tile reset without source change");
  chk_trst_hold: assert property ($fell(tile_reset_out) |->
    $past(gate_int_out || gate_xtal_out, 8))
    else $error("tile reset released before new source ran");
endmodule : osc_ctrl_monitor

bind oscillator_select_control osc_ctrl_monitor u_mon (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .strap_sel_in(strap_sel_in), .req_in(req_in),
  .xtal_ready_in(xtal_ready_in), .int_ready_in(int_ready_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .sel_internal_out(sel_internal_out),
  .gate_xtal_out(gate_xtal_out), .gate_int_out(gate_int_out),
  .osc_ctrl_out(osc_ctrl_out), .tile_reset_out(tile_reset_out)
);

//--- tb/oscillator_select_control_tb.sv
// Self-checking bench for the oscillator select control block.
// Assumes the checker file is compiled alongside; bench acts as software.
module oscillator_select_control_tb
  import osc_ctrl_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        strap_sel_in = 1'b0;
  periph_req_s req_in = '0;
  logic        xtal_ready_in = 1'b1;
  logic        int_ready_in = 1'b0;
  logic [7:0]  rdata_out;
  logic        rvalid_out, sel_internal_out, gate_xtal_out, gate_int_out, tile_reset_out;
  osc_ctrl_s   osc_ctrl_out;
  logic [7:0]  expq[$];
  logic [7:0]  rnd;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  integer      seed = 72;
  always #4 clk_in = ~clk_in;
  oscillator_select_control dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .strap_sel_in(strap_sel_in), .req_in(req_in),
    .xtal_ready_in(xtal_ready_in), .int_ready_in(int_ready_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .sel_internal_out(sel_internal_out),
    .gate_xtal_out(gate_xtal_out), .gate_int_out(gate_int_out),
    .osc_ctrl_out(osc_ctrl_out), .tile_reset_out(tile_reset_out));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task access(input logic wr, input logic [7:0] per, input logic [7:0] adr,
              input logic [7:0] dat, input logic [7:0] exp);
    @(posedge clk_in);
    req_in <= '{1'b1, wr, per, adr, dat};
    if (!wr && per == 8'h04)
      expq.push_back(exp);
    @(posedge clk_in);
    req_in.valid <= 1'b0;
  endtask : access
  task rd(input logic [7:0] adr, input logic [7:0] exp);
    access(1'b0, 8'h04, adr, 8'h00, exp);
  endtask : rd
  task wr(input logic [7:0] adr, input logic [7:0] dat);
    access(1'b1, 8'h04, adr, dat, 8'h00);
  endtask : wr
  // Watcher: every read answer takes the oldest note; timeout ceiling too
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      tally_and_finish();
    end
    if (rvalid_out === 1'b1)
      check("read data", (expq.size() > 0) ? expq.pop_front() : 8'hxx, rdata_out);
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h01);
    rd(8'h02, 8'h03);
    check("osc ctrl", 8'h0e, {4'h0, osc_ctrl_out});
    access(1'b0, 8'h03, 8'h00, 8'h00, 8'h00);
    access(1'b1, 8'h03, 8'h01, 8'h00, 8'h00);
    rd(8'h01, 8'h01);
    rd(8'h07, 8'h00);
    wr(8'h00, 8'hfe);
    rd(8'h00, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      rnd = 8'($random(seed));
      // clearing internal enable is safe on crystal
      wr(8'h01, rnd);
      // crystal stays enabled while it drives the tile
      wr(8'h02, rnd | 8'h01);
      rd(8'h01, rnd & 8'h03);
      rd(8'h02, (rnd & 8'h03) | 8'h01);
      check("xtal ctrl", {6'h0, 1'b1, rnd[1]}, {6'h0, osc_ctrl_out[3:2]});
      check("int ctrl", {6'h0, rnd[0], rnd[1]}, {6'h0, osc_ctrl_out[1:0]});
    end
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h03);
    for (int i = 0; i < 20 && tile_reset_out !== 1'b1; i++) @(posedge clk_in);
    check("tile reset", 8'h01, {7'h0, tile_reset_out});
    int_ready_in <= 1'b1;
    for (int i = 0; i < 40 && gate_int_out !== 1'b1; i++) @(posedge clk_in);
    check("internal gate", 8'h01, {7'h0, gate_int_out});
    check("source", 8'h01, {7'h0, sel_internal_out});
    for (int i = 0; i < 40 && tile_reset_out !== 1'b0; i++) @(posedge clk_in);
    check("tile released", 8'h00, {7'h0, tile_reset_out});
    rd(8'h00, 8'h03);
    // crystal may stop while the internal source runs
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h02, 8'h03);
    wr(8'h00, 8'h00);
    for (int i = 0; i < 40 && gate_xtal_out !== 1'b1; i++) @(posedge clk_in);
    check("crystal gate", 8'h01, {7'h0, gate_xtal_out});
    check("no tile reset", 8'h00, {7'h0, tile_reset_out});
    arst_n_in <= 1'b0;
    strap_sel_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h00, 8'h01);
    for (int i = 0; i < 40 && gate_int_out !== 1'b1; i++) @(posedge clk_in);
    check("strap source", 8'h01, {7'h0, sel_internal_out});
    tally_and_finish();
  end
endmodule : oscillator_select_control_tb
